// ### shared/rer_defs.svh
// register map, field positions and reset values of the error record node
`ifndef RER_DEFS_SVH
`define RER_DEFS_SVH
`define RER_IDX_ADDR_LO   5'h00
`define RER_IDX_ADDR_HI   5'h01
`define RER_IDX_CTL_LO    5'h02
`define RER_IDX_CTL_HI    5'h03
`define RER_IDX_FEAT_LO   5'h04
`define RER_IDX_FEAT_HI   5'h05
`define RER_IDX_MISC0_LO  5'h06
`define RER_IDX_MISC0_HI  5'h07
`define RER_IDX_MISC1_LO  5'h08
`define RER_IDX_MISC1_HI  5'h09
`define RER_IDX_CDOWN     5'h0a
`define RER_IDX_INJCTL    5'h0b
`define RER_IDX_STATUS    5'h0c
`define RER_CTL_DETECT    0
`define RER_CTL_RECOV_IRQ 2
`define RER_CTL_FAULT_IRQ 3
`define RER_CTL_CORR_IRQ  8
`define RER_CTL_MASK      32'h0000010d
`define RER_CTL_RESET     64'h0000000000000000
`define RER_ADDR_RESET    64'h0000000000000000
`define RER_FEAT_VALUE    64'h000000000000a9a6
`define RER_MISC_RESET    64'h0000000000000000
`define RER_MISC_LO_MASK  32'hf007ffcf
`define RER_CDOWN_RESET   32'h00000000
`define RER_INJ_RESET     32'h00000000
`define RER_INJ_ENABLE    31
`define RER_INJ_RESTART   30
`define RER_INJ_CORR      6
`define RER_INJ_DEFER     5
`define RER_INJ_UNCORR    3
`define RER_INJ_MASK      32'hc0000068
`define RER_STAT_UNCORR   29
`define RER_STAT_DEFER    23
`define RER_OTHER_OVF_BIT 47
`define RER_OTHER_CNT_LSB 40
`define RER_REPEAT_OVF_BIT 39
`define RER_REPEAT_CNT_LSB 32
`define RER_WAY_LSB       28
`define RER_INDEX_LSB     6
`define RER_LEVEL_LSB     1
`define RER_CNT_MAX       7'h7f
`endif

// ### shared/rer_pkg.sv
// types shared by the error record node
package rer_pkg;
  typedef struct packed {
    logic        corrected;
    logic        deferred;
    logic        uncorrected;
    logic [1:0]  way;
    logic [12:0] index;
    logic [2:0]  level;
    logic        instr_side;
  } rer_err_t;
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  idx;
    logic [31:0] wdata;
  } rer_req_t;
  typedef struct packed {
    logic corrected;
    logic deferred;
    logic uncorrected;
  } rer_inject_t;
  typedef enum logic [1:0] {
    RER_CNT_IDLE = 2'b00,
    RER_CNT_RUN  = 2'b01,
    RER_CNT_DONE = 2'b10
  } rer_cnt_state_t;
endpackage : rer_pkg

// ### rtl/rer_node.sv
// error record node: control, features, syndrome counters and fault injection countdown
`timescale 1ns/1ps
`default_nettype none
`include "rer_defs.svh"
module rer_node (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [3:0]           record_selector,
  input  wire rer_pkg::rer_req_t    req,
  input  wire rer_pkg::rer_err_t    err,
  input  wire logic                 status_clear_uncorr,
  output logic [31:0]               rdata,
  output logic                      detection_enable,
  output logic                      fault_irq,
  output logic                      recovery_irq,
  output rer_pkg::rer_inject_t      inject
);
  import rer_pkg::*;

  // register state
  logic [63:0]    ctl_q;
  logic [63:0]    misc_q;
  logic [63:0]    misc_d;
  logic [31:0]    countdown_value_q;
  logic [31:0]    inj_ctl_q;
  logic [31:0]    inj_cnt_q;
  logic           uncorrected_flag_q;
  logic           deferred_flag_q;
  rer_cnt_state_t cnt_state_q;
  logic [63:0]    feat_word;

  // access decode
  logic           sel_ok;
  logic           wr_en;
  logic           rd_en;
  logic           ctl_wr;
  logic           misc_lo_wr;
  logic           misc_hi_wr;
  logic           cdown_wr;
  logic           inj_ctl_wr;
  logic           status_wr;
  logic [31:0]    rd_word;

  // error path
  logic           err_seen;
  logic           corr_event;
  logic           defer_event;
  logic           uncorr_event;
  logic           loc_match;
  logic           way_match;
  logic           index_match;
  logic           level_match;
  logic           side_match;
  logic           ovf_pending;
  logic [1:0]     cnt_hit;
  logic [1:0]     cnt_wrap;
  logic [6:0]     cnt_field [2];
  logic [6:0]     cnt_next  [2];

  // injection counter
  logic           countdown_enable;
  logic           restart;
  logic           cnt_zero;
  logic           inj_active;
  logic           inj_fire;

  // a non-zero selector hides the whole record, reads included
  assign sel_ok     = (record_selector == 4'h0);
  assign wr_en      = req.wr && sel_ok;
  assign rd_en      = req.rd && sel_ok;
  assign ctl_wr     = wr_en && (req.idx == `RER_IDX_CTL_LO);
  assign misc_lo_wr = wr_en && (req.idx == `RER_IDX_MISC0_LO);
  assign misc_hi_wr = wr_en && (req.idx == `RER_IDX_MISC0_HI);
  assign cdown_wr   = wr_en && (req.idx == `RER_IDX_CDOWN);
  assign inj_ctl_wr = wr_en && (req.idx == `RER_IDX_INJCTL);
  assign status_wr  = wr_en && (req.idx == `RER_IDX_STATUS);

  // features are wired constants; no storage needed
  assign feat_word  = `RER_FEAT_VALUE;

  // detection off masks every reported error; ecc generation on writes lives in the datapath
  assign err_seen     = ctl_q[`RER_CTL_DETECT];
  assign corr_event   = err_seen && err.corrected;
  assign defer_event  = err_seen && err.deferred;
  assign uncorr_event = err_seen && err.uncorrected && !err.deferred;

  // location compare; the way field uses only its two upper bits
  assign way_match   = (misc_q[`RER_WAY_LSB+3 -: 2] == err.way);
  assign index_match = (misc_q[`RER_INDEX_LSB+12:`RER_INDEX_LSB] == err.index);
  assign level_match = (misc_q[`RER_LEVEL_LSB+2:`RER_LEVEL_LSB] == err.level);
  assign side_match  = (misc_q[0] == err.instr_side);
  assign loc_match   = way_match && index_match && level_match && side_match;

  // entry 0 is the repeat count, entry 1 the other count
  for (genvar g = 0; g < 2; g++) begin : g_cnt
    localparam int LSB = (g == 0) ? `RER_REPEAT_CNT_LSB : `RER_OTHER_CNT_LSB;
    assign cnt_field[g] = misc_q[LSB +: 7];
    // counts wrap to zero; the overflow flag keeps the news
    assign cnt_next[g]  = cnt_field[g] + 7'h01;
    assign cnt_hit[g]   = corr_event && (loc_match == (g == 0));
    assign cnt_wrap[g]  = cnt_hit[g] && (cnt_field[g] == `RER_CNT_MAX);
  end

  // control register, only defined bits are stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= `RER_CTL_RESET;
    end else if (ctl_wr) begin
      ctl_q <= {32'h0, req.wdata & `RER_CTL_MASK};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detection_enable <= 1'b0;
    end else begin
      detection_enable <= ctl_q[`RER_CTL_DETECT];
    end
  end

  // syndrome counters: hardware increments win over a software write in the same cycle
  always_comb begin
    misc_d = misc_q;
    if (misc_lo_wr) begin
      misc_d[31:0] = req.wdata & `RER_MISC_LO_MASK;
    end else if (misc_hi_wr) begin
      misc_d[63:32] = {16'h0, req.wdata[15:0]};
    end
    if (cnt_hit[0]) begin
      misc_d[`RER_REPEAT_CNT_LSB +: 7] = cnt_next[0];
    end
    if (cnt_wrap[0]) begin
      misc_d[`RER_REPEAT_OVF_BIT] = 1'b1;
    end
    if (cnt_hit[1]) begin
      misc_d[`RER_OTHER_CNT_LSB +: 7] = cnt_next[1];
      // a new location takes over the record; the low way bits stay zero
      misc_d[31:28] = {err.way, 2'b00};
      misc_d[`RER_INDEX_LSB+12:`RER_INDEX_LSB] = err.index;
      misc_d[`RER_LEVEL_LSB+2:`RER_LEVEL_LSB] = err.level;
      misc_d[0] = err.instr_side;
    end
    if (cnt_wrap[1]) begin
      misc_d[`RER_OTHER_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      misc_q <= `RER_MISC_RESET;
    end else begin
      misc_q <= misc_d;
    end
  end

  // minimal status, uncorrected flag: set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uncorrected_flag_q <= 1'b0;
    end else if (uncorr_event) begin
      uncorrected_flag_q <= 1'b1;
    end else if (status_clear_uncorr) begin
      uncorrected_flag_q <= 1'b0;
    end
  end

  // minimal status, deferred flag: write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deferred_flag_q <= 1'b0;
    end else if (defer_event) begin
      deferred_flag_q <= 1'b1;
    end else if (status_wr && req.wdata[`RER_STAT_DEFER]) begin
      deferred_flag_q <= 1'b0;
    end
  end

  // looks at next-state flags so a clear and an overflow in one cycle keep the interrupt
  assign ovf_pending = misc_d[`RER_OTHER_OVF_BIT] || misc_d[`RER_REPEAT_OVF_BIT];

  // corrected path reads only the counters, so a higher priority record cannot hide it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_irq <= 1'b0;
    end else begin
      fault_irq <= (ctl_q[`RER_CTL_CORR_IRQ] && ovf_pending) ||
                   (ctl_q[`RER_CTL_FAULT_IRQ] && (defer_event || (err_seen && err.uncorrected)));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      recovery_irq <= 1'b0;
    end else begin
      recovery_irq <= ctl_q[`RER_CTL_RECOV_IRQ] && (uncorr_event || uncorrected_flag_q);
    end
  end

  // countdown value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      countdown_value_q <= `RER_CDOWN_RESET;
    end else if (cdown_wr) begin
      countdown_value_q <= req.wdata;
    end
  end

  // injection control, reserved bits dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inj_ctl_q <= `RER_INJ_RESET;
    end else if (inj_ctl_wr) begin
      inj_ctl_q <= req.wdata & `RER_INJ_MASK;
    end
  end

  assign countdown_enable = inj_ctl_q[`RER_INJ_ENABLE];
  assign restart          = inj_ctl_q[`RER_INJ_RESTART];
  assign cnt_zero         = (inj_cnt_q == 32'h0);
  // a control write restarts the sequence, so every enabling write reloads the count
  assign inj_active       = countdown_enable && !inj_ctl_wr;
  assign inj_fire         = inj_active && (cnt_state_q == RER_CNT_RUN) && cnt_zero;

  // counter sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_state_q <= RER_CNT_IDLE;
    end else if (!inj_active) begin
      cnt_state_q <= RER_CNT_IDLE;
    end else begin
      case (cnt_state_q)
        RER_CNT_IDLE: begin
          cnt_state_q <= RER_CNT_RUN;
        end
        RER_CNT_RUN: begin
          if (cnt_zero && !restart) begin
            cnt_state_q <= RER_CNT_DONE;
          end
        end
        default: begin
          cnt_state_q <= RER_CNT_DONE;
        end
      endcase
    end
  end

  // counter value; it holds while disabled and is reloaded on the next enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inj_cnt_q <= 32'h0;
    end else if (inj_active) begin
      if (cnt_state_q == RER_CNT_IDLE) begin
        inj_cnt_q <= countdown_value_q;
      end else if (cnt_state_q == RER_CNT_RUN) begin
        if (!cnt_zero) begin
          inj_cnt_q <= inj_cnt_q - 32'h1;
        end else if (restart) begin
          inj_cnt_q <= countdown_value_q;
        end
      end
    end
  end

  // one-cycle injection pulse for each enabled error type
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inject <= '0;
    end else begin
      inject.corrected   <= inj_fire && inj_ctl_q[`RER_INJ_CORR];
      inject.deferred    <= inj_fire && inj_ctl_q[`RER_INJ_DEFER];
      inject.uncorrected <= inj_fire && inj_ctl_q[`RER_INJ_UNCORR];
    end
  end

  // read mux; upper half of each 64-bit register is a separate alias
  always_comb begin
    rd_word = 32'h0;
    if (req.idx == `RER_IDX_ADDR_LO || req.idx == `RER_IDX_ADDR_HI) begin
      rd_word = 32'h0;
    end else if (req.idx == `RER_IDX_CTL_LO) begin
      rd_word = ctl_q[31:0];
    end else if (req.idx == `RER_IDX_CTL_HI) begin
      rd_word = ctl_q[63:32];
    end else if (req.idx == `RER_IDX_FEAT_LO) begin
      rd_word = feat_word[31:0];
    end else if (req.idx == `RER_IDX_FEAT_HI) begin
      rd_word = feat_word[63:32];
    end else if (req.idx == `RER_IDX_MISC0_LO) begin
      rd_word = misc_q[31:0];
    end else if (req.idx == `RER_IDX_MISC0_HI) begin
      rd_word = misc_q[63:32];
    end else if (req.idx == `RER_IDX_MISC1_LO || req.idx == `RER_IDX_MISC1_HI) begin
      rd_word = 32'h0;
    end else if (req.idx == `RER_IDX_CDOWN) begin
      rd_word = countdown_value_q;
    end else if (req.idx == `RER_IDX_INJCTL) begin
      rd_word = inj_ctl_q;
    end else if (req.idx == `RER_IDX_STATUS) begin
      rd_word = {2'b00, uncorrected_flag_q, 5'h0, deferred_flag_q, 23'h0};
    end else begin
      rd_word = 32'h0;
    end
  end

  // read data stands one cycle only, zero otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0;
    end else if (rd_en) begin
      rdata <= rd_word;
    end else begin
      rdata <= 32'h0;
    end
  end
endmodule : rer_node
`default_nettype wire

// ### tb/rer_node_checker.sv
// assertion checker for the error record node
`timescale 1ns/1ps
`default_nettype none
module rer_node_checker (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic [3:0]           record_selector,
  input wire rer_pkg::rer_req_t    req,
  input wire rer_pkg::rer_err_t    err,
  input wire logic                 status_clear_uncorr,
  input wire logic [31:0]          rdata,
  input wire logic                 detection_enable,
  input wire logic                 fault_irq,
  input wire logic                 recovery_irq,
  input wire rer_pkg::rer_inject_t inject
);
  import rer_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rd0 = req.rd && record_selector == 4'h0;
  wire wc  = req.wr && record_selector == 4'h0 && req.idx == 5'h02;
  a_feat_value: assert property (rd0 && req.idx == 5'h04 |=> rdata == 32'h0000a9a6)
    else $error("feature read wrong");
  a_rsvd_zero: assert property (rd0 && req.idx inside {5'h00, 5'h01, 5'h08, 5'h09} |=> rdata == 32'h0)
    else $error("reserved read nonzero");
  a_idle_rdata: assert property (!rd0 |=> rdata == 32'h0)
    else $error("read data without taken read");
  a_ctl_mask: assert property (wc ##1 !req.wr ##1 rd0 && req.idx == 5'h02
    |=> rdata == ($past(req.wdata, 3) & 32'h0000010d)) else $error("control readback wrong");
  a_detect_copy: assert property (wc |-> ##2 detection_enable == $past(req.wdata[0], 2))
    else $error("detection enable not following control");
  a_rec_cause: assert property ($rose(recovery_irq) |-> $past(err.uncorrected) || $past(err.uncorrected, 2)
    || $past(req.wr) || $past(req.wr, 2)) else $error("recovery irq without cause");
  a_rec_clear: assert property (status_clear_uncorr && !err.uncorrected ##1 !err.uncorrected |=> !recovery_irq)
    else $error("recovery irq held after clear");
  a_fault_cause: assert property ($rose(fault_irq) |-> $past(err.corrected || err.deferred || err.uncorrected)
    || $past(err.corrected || err.deferred || err.uncorrected, 2) || $past(req.wr) || $past(req.wr, 2))
    else $error("fault irq without cause");
endmodule : rer_node_checker
bind rer_node rer_node_checker rer_node_checker_i (.clk(clk), .rst_n(rst_n), .record_selector(record_selector),
  .req(req), .err(err), .status_clear_uncorr(status_clear_uncorr), .rdata(rdata),
  .detection_enable(detection_enable),
  .fault_irq(fault_irq), .recovery_irq(recovery_irq), .inject(inject));
`default_nettype wire

// ### tb/rer_node_tb.sv
// self-checking bench for the error record node
`timescale 1ns/1ps
`default_nettype none
module rer_node_tb;
  import rer_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [3:0]  record_selector;
  rer_req_t    req;
  rer_err_t    err;
  logic        status_clear_uncorr;
  logic [31:0] rdata;
  logic        detection_enable;
  logic        fault_irq;
  logic        recovery_irq;
  rer_inject_t inject;
  int          errors;
  int          n_checks;
  int          cyc;
  int          np;
  logic        f_seen;
  logic        r_seen;
  rer_node rer_node_i (.clk(clk), .rst_n(rst_n), .record_selector(record_selector), .req(req), .err(err),
    .status_clear_uncorr(status_clear_uncorr), .rdata(rdata), .detection_enable(detection_enable),
    .fault_irq(fault_irq), .recovery_irq(recovery_irq), .inject(inject));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ceiling well above the roughly 1560 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // an idle edge after each access keeps a strobe from being driven twice in one step
  task automatic wr(logic [4:0] idx, logic [31:0] d);
    req <= '{1'b0, 1'b1, idx, d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : wr
  task automatic rd(logic [4:0] idx, logic [31:0] exp);
    req <= '{1'b1, 1'b0, idx, 32'h0};
    @(posedge clk);
    req <= '0;
    #1 chk($sformatf("reg %h", idx), rdata, exp);
    @(posedge clk);
  endtask : rd
  task automatic ev(logic [2:0] k, logic [1:0] w, logic [12:0] x);
    err <= '{k[2], k[1], k[0], w, x, 3'h1, 1'b1};
    @(posedge clk);
    err <= '0;
    f_seen = 1'b0;
    r_seen = 1'b0;
    // the first look falls in the cycle the one-cycle fault pulse stands
    repeat (3) begin
      #1 f_seen |= fault_irq;
      r_seen |= recovery_irq;
      @(posedge clk);
    end
    @(posedge clk);
  endtask : ev
  task automatic count_inj(logic [2:0] k);
    np = 0;
    repeat (40) begin
      @(posedge clk);
      #1 np += int'(inject === k);
    end
    @(posedge clk);
  endtask : count_inj
  initial begin
    rst_n = 1'b0;
    record_selector = 4'h0;
    req = '0;
    err = '0;
    status_clear_uncorr = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 13; i++) rd(5'(i), i == 4 ? 32'h0000a9a6 : 32'h0);
    rd(5'h1f, 32'h0);
    $display("test reset values done");
    wr(5'h02, 32'hffffffff);
    rd(5'h02, 32'h0000010d);
    #1 chk("detect", detection_enable, 1);
    @(posedge clk);
    wr(5'h03, 32'hffffffff);
    rd(5'h03, 32'h0);
    wr(5'h04, 32'h0);
    rd(5'h04, 32'h0000a9a6);
    wr(5'h00, 32'hffffffff);
    wr(5'h09, 32'hffffffff);
    rd(5'h00, 32'h0);
    rd(5'h09, 32'h0);
    wr(5'h0a, 32'h12345678);
    record_selector <= 4'h3;
    wr(5'h0a, 32'h0);
    rd(5'h0a, 32'h0);
    record_selector <= 4'h0;
    rd(5'h0a, 32'h12345678);
    $display("test access done");
    wr(5'h02, 32'h0);
    ev(3'b100, 2'h2, 13'h155);
    rd(5'h07, 32'h0);
    wr(5'h02, 32'h00000101);
    ev(3'b100, 2'h2, 13'h155);
    rd(5'h06, 32'h80005543);
    rd(5'h07, 32'h00000100);
    repeat (128) ev(3'b100, 2'h2, 13'h155);
    chk("fault on wrap", f_seen, 1);
    rd(5'h07, 32'h00000180);
    repeat (20) @(posedge clk);
    #1 chk("fault held", fault_irq, 1);
    @(posedge clk);
    wr(5'h07, 32'h0);
    rd(5'h07, 32'h0);
    #1 chk("fault cleared", fault_irq, 0);
    @(posedge clk);
    wr(5'h02, 32'h00000001);
    for (int i = 0; i < 128; i++) ev(3'b100, 2'h1, 13'(i % 2));
    chk("fault masked", f_seen, 0);
    rd(5'h07, 32'h00008000);
    wr(5'h02, 32'h00000101);
    rd(5'h02, 32'h00000101);
    #1 chk("fault by enable", fault_irq, 1);
    @(posedge clk);
    wr(5'h07, 32'h0);
    $display("test counters done");
    wr(5'h02, 32'h0000000d);
    ev(3'b001, 2'h0, 13'h0);
    chk("fault uncorr", f_seen, 1);
    chk("recov uncorr", r_seen, 1);
    #1 chk("recov held", recovery_irq, 1);
    @(posedge clk);
    status_clear_uncorr <= 1'b1;
    @(posedge clk);
    status_clear_uncorr <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("recov cleared", recovery_irq, 0);
    @(posedge clk);
    ev(3'b010, 2'h0, 13'h0);
    chk("fault defer", f_seen, 1);
    chk("recov defer", r_seen, 0);
    wr(5'h02, 32'h00000001);
    ev(3'b001, 2'h0, 13'h0);
    chk("fault off", f_seen, 0);
    chk("recov off", r_seen, 0);
    $display("test interrupts done");
    wr(5'h0a, 32'h00000005);
    wr(5'h0b, 32'hc0000068);
    count_inj(3'b111);
    chk("restart pulses", 32'(np >= 2), 1);
    wr(5'h0b, 32'h80000040);
    count_inj(3'b100);
    chk("single pulse", 32'(np), 1);
    wr(5'h0b, 32'h0);
    count_inj(3'b100);
    chk("disabled", 32'(np), 0);
    $display("test injection done");
    report_and_stop();
  end
endmodule : rer_node_tb
`default_nettype wire
